// ---- hdl/interrupt_enable_logic.sv ----
// interrupt enable logic: source flags, per-source and global gating, requests
// assumes core-domain peripheral events and write strobes; pins are asynchronous
`timescale 1ns/1ps
module interrupt_enable_logic (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // external pins, active low
  input wire logic ext_irq_pin_zero_n,
  input wire logic ext_irq_pin_one_n,
  // enable register port
  input wire logic enable_write,
  input wire logic [7:0] enable_wdata,
  input wire logic spi_irq_enable,
  // peripheral events and software flag actions
  input wire irq_enable_pkg::event_type events,
  input wire irq_enable_pkg::flag_ctrl_type flag_ctrl,
  input wire logic vector_taken,
  // outputs
  output logic [7:0] interrupt_enable,
  output irq_enable_pkg::request_type requests,
  output logic timer2_overflow_flag,
  output logic timer2_external_flag,
  output logic spi_done_flag,
  output logic sample_strobe
);
  import irq_enable_pkg::*;

  logic [1:0] pin0_sync;
  logic [1:0] pin1_sync;
  logic [3:0] tick;
  logic timer0_overflow_flag;
  logic timer1_overflow_flag;
  logic timer0_pending;
  logic timer1_pending;
  logic timer0_seen;
  logic timer1_seen;
  logic timer2_seen;
  logic spi_status_armed;
  logic uart_flag;
  request_type next_requests;

  // pin synchronisers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin0_sync <= 2'h3;
      pin1_sync <= 2'h3;
    end else begin
      pin0_sync <= {pin0_sync[0], ext_irq_pin_zero_n};
      pin1_sync <= {pin1_sync[0], ext_irq_pin_one_n};
    end
  end

  // machine cycle state and phase counter
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tick <= TICK_RESET;
    end else if (tick == TICK_LAST) begin
      tick <= TICK_RESET;
    end else begin
      tick <= tick + 4'h1;
    end
  end

  // enable register, reserved bit kept at zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      interrupt_enable <= ENABLE_RESET;
    end else if (enable_write) begin
      interrupt_enable <= enable_wdata & ENABLE_IMPL_MASK;
    end
  end

  // timer0/1 overflows latched until s5p2, set wins over clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      timer0_pending <= 1'b0;
      timer1_pending <= 1'b0;
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
    end else begin
      timer0_pending <= (timer0_pending | events.timer0_overflow) & (tick != TICK_S5P2);
      timer1_pending <= (timer1_pending | events.timer1_overflow) & (tick != TICK_S5P2);
      if (tick == TICK_S5P2 && (timer0_pending || events.timer0_overflow)) begin
        timer0_overflow_flag <= 1'b1;
      end else if (flag_ctrl.timer0_clear || vector_taken && requests.timer0) begin
        timer0_overflow_flag <= 1'b0;
      end
      if (tick == TICK_S5P2 && (timer1_pending || events.timer1_overflow)) begin
        timer1_overflow_flag <= 1'b1;
      end else if (flag_ctrl.timer1_clear || vector_taken && requests.timer1) begin
        timer1_overflow_flag <= 1'b0;
      end
    end
  end

  // timer2 flags: set on the event in any phase, cleared only by software
  always_ff @(posedge core_clk) begin
    if (srst) begin
      timer2_overflow_flag <= 1'b0;
      timer2_external_flag <= 1'b0;
    end else begin
      if (events.timer2_overflow) begin
        timer2_overflow_flag <= 1'b1;
      end else if (flag_ctrl.timer2_overflow_clear) begin
        timer2_overflow_flag <= 1'b0;
      end
      if (events.timer2_external) begin
        timer2_external_flag <= 1'b1;
      end else if (flag_ctrl.timer2_external_clear) begin
        timer2_external_flag <= 1'b0;
      end
    end
  end

  // spi done flag with status-read then data-access clear; uart flag
  always_ff @(posedge core_clk) begin
    if (srst) begin
      spi_done_flag <= 1'b0;
      spi_status_armed <= 1'b0;
      uart_flag <= 1'b0;
    end else begin
      uart_flag <= events.uart_flag;
      if (events.spi_done) begin
        spi_done_flag <= 1'b1;
        spi_status_armed <= 1'b0;
      end else if (spi_status_armed && flag_ctrl.spi_data_access) begin
        spi_done_flag <= 1'b0;
        spi_status_armed <= 1'b0;
      end else if (flag_ctrl.spi_status_read && spi_done_flag) begin
        spi_status_armed <= 1'b1;
      end
    end
  end

  // sampling points: timer0/1 one clock after the s5p2 set, timer2 one clock after s2p2, both in the same machine cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      timer0_seen <= 1'b0;
      timer1_seen <= 1'b0;
      timer2_seen <= 1'b0;
    end else begin
      if (tick == TICK_S5P2 + 4'h1) begin
        timer0_seen <= timer0_overflow_flag;
        timer1_seen <= timer1_overflow_flag;
      end
      if (tick == TICK_S2P2 + 4'h1) begin
        timer2_seen <= timer2_overflow_flag | timer2_external_flag;
      end else if (!(timer2_overflow_flag | timer2_external_flag)) begin
        timer2_seen <= 1'b0;
      end
    end
  end

  // gating of every source by its enable and the global enable
  always_comb begin
    next_requests = '0;
    if (interrupt_enable[BIT_GLOBAL]) begin
      next_requests.ext0 = interrupt_enable[BIT_EXT0] & ~pin0_sync[1];
      next_requests.ext1 = interrupt_enable[BIT_EXT1] & ~pin1_sync[1];
      next_requests.timer0 = interrupt_enable[BIT_TIMER0] & timer0_seen & timer0_overflow_flag;
      next_requests.timer1 = interrupt_enable[BIT_TIMER1] & timer1_seen & timer1_overflow_flag;
      next_requests.timer2 = interrupt_enable[BIT_TIMER2] & timer2_seen;
      next_requests.serial = interrupt_enable[BIT_SERIAL] &
                             ((spi_done_flag & spi_irq_enable) | uart_flag);
    end
  end

  // registered requests and sample strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      requests <= '0;
      sample_strobe <= 1'b0;
    end else begin
      requests <= next_requests;
      sample_strobe <= (tick == TICK_S5P2 + 4'h1);
    end
  end

  // register, gating and flag assertions
  a_reserved_bit_zero: assert property (@(posedge core_clk) disable iff (srst)
    interrupt_enable[BIT_RESERVED] == 1'b0) else $error("reserved enable bit set");
  a_global_blocks_all: assert property (@(posedge core_clk) disable iff (srst)
    !$past(interrupt_enable[BIT_GLOBAL]) |-> requests == '0) else $error("request with global off");
  a_enable_write_stores: assert property (@(posedge core_clk) disable iff (srst)
    enable_write |=> interrupt_enable == ($past(enable_wdata) & 8'hBF)) else $error("enable write lost");
  a_timer2_no_hw_clear: assert property (@(posedge core_clk) disable iff (srst)
    timer2_overflow_flag && !flag_ctrl.timer2_overflow_clear |=> timer2_overflow_flag)
    else $error("timer2 flag cleared by hardware");
  a_timer0_set_s5p2: assert property (@(posedge core_clk) disable iff (srst)
    $rose(timer0_overflow_flag) |-> $past(tick) == TICK_S5P2) else $error("timer0 flag off phase");
  a_spi_clear_order: assert property (@(posedge core_clk) disable iff (srst)
    $fell(spi_done_flag) |-> $past(spi_status_armed)) else $error("spi flag cleared early");
  a_serial_needs_enable: assert property (@(posedge core_clk) disable iff (srst)
    requests.serial |-> $past(interrupt_enable[BIT_SERIAL])) else $error("serial without enable");
  a_timer2_or: assert property (@(posedge core_clk) disable iff (srst)
    requests.timer2 |-> $past(timer2_overflow_flag || timer2_external_flag, 2)) else $error("timer2 no cause");
  a_ext0_held: assert property (@(posedge core_clk) disable iff (srst)
    interrupt_enable[BIT_GLOBAL] && interrupt_enable[BIT_EXT0] && !pin0_sync[1] && !enable_write
    |=> requests.ext0) else $error("ext0 request dropped");
  a_timer2_same_cycle: assert property (@(posedge core_clk) disable iff (srst)
    events.timer2_overflow && tick == TICK_S2P2 && interrupt_enable == 8'hA0 && !enable_write
    ##1 !flag_ctrl.timer2_overflow_clear |-> ##2 requests.timer2) else $error("timer2 sampled late");

  // timer1 flag only rises at s5p2
  a_timer1_set_s5p2: assert property (@(posedge core_clk) disable iff (srst)
    $rose(timer1_overflow_flag) |-> $past(tick) == TICK_S5P2) else $error("timer1 flag off phase");

  // timer0 sample taken in the cycle after the flag was set
  a_timer0_sampled_late: assert property (@(posedge core_clk) disable iff (srst)
    $rose(timer0_seen) |-> $past(tick) == TICK_S5P2 + 4'h1) else $error("timer0 sampled off phase");

  // timer1 sample taken in the cycle after the flag was set
  a_timer1_sampled_late: assert property (@(posedge core_clk) disable iff (srst)
    $rose(timer1_seen) |-> $past(tick) == TICK_S5P2 + 4'h1) else $error("timer1 sampled off phase");

  // timer2 sample taken right after s2p2
  a_timer2_sample_point: assert property (@(posedge core_clk) disable iff (srst)
    $rose(timer2_seen) |-> $past(tick) == TICK_S2P2 + 4'h1) else $error("timer2 sampled off phase");

  // timer2 external flag survives everything but a software clear
  a_timer2_ext_kept: assert property (@(posedge core_clk) disable iff (srst)
    timer2_external_flag && !flag_ctrl.timer2_external_clear |=> timer2_external_flag)
    else $error("timer2 external flag cleared by hardware");

  // external event sets its timer2 flag
  a_timer2_ext_sets: assert property (@(posedge core_clk) disable iff (srst)
    events.timer2_external |=> timer2_external_flag) else $error("timer2 external flag not set");

  // finished spi byte sets the done flag
  a_spi_done_sets: assert property (@(posedge core_clk) disable iff (srst)
    events.spi_done |=> spi_done_flag) else $error("spi done flag not set");

  // clear sequence is armed only while the flag stands
  a_spi_armed_flag: assert property (@(posedge core_clk) disable iff (srst)
    spi_status_armed |-> spi_done_flag) else $error("spi clear armed without flag");

  // serial line without uart cause needs spi enable and done flag
  a_serial_spi_gate: assert property (@(posedge core_clk) disable iff (srst)
    requests.serial && !$past(uart_flag) |-> $past(spi_irq_enable && spi_done_flag))
    else $error("serial request without spi cause");

  // uart cause reaches the shared serial line
  a_uart_to_serial: assert property (@(posedge core_clk) disable iff (srst)
    interrupt_enable[BIT_GLOBAL] && interrupt_enable[BIT_SERIAL] && uart_flag && !enable_write
    |=> requests.serial) else $error("uart request lost");

  // a cleared own enable blocks its source
  a_timer0_off_blocks: assert property (@(posedge core_clk) disable iff (srst)
    !$past(interrupt_enable[BIT_TIMER0]) |-> !requests.timer0) else $error("timer0 without enable");

  // one sample strobe per machine cycle
  a_strobe_spacing: assert property (@(posedge core_clk) disable iff (srst)
    sample_strobe |=> !sample_strobe [*8]) else $error("sample strobe too often");

  // timer2 request stands while sampled cause and enables stand
  a_timer2_held: assert property (@(posedge core_clk) disable iff (srst)
    interrupt_enable[BIT_GLOBAL] && interrupt_enable[BIT_TIMER2] && timer2_seen && !enable_write
    |=> requests.timer2) else $error("timer2 request dropped");

  // ext1 request stands while pin and enables stand
  a_ext1_held: assert property (@(posedge core_clk) disable iff (srst)
    interrupt_enable[BIT_GLOBAL] && interrupt_enable[BIT_EXT1] && !pin1_sync[1] && !enable_write
    |=> requests.ext1) else $error("ext1 request dropped");

  // machine cycle counter stays inside its twelve states
  a_tick_in_range: assert property (@(posedge core_clk) disable iff (srst)
    tick <= TICK_LAST) else $error("machine cycle counter out of range");

  // main scenarios
  c_timer0_request: cover property (@(posedge core_clk) disable iff (srst) $rose(requests.timer0));

  c_ext0_request: cover property (@(posedge core_clk) disable iff (srst) $rose(requests.ext0));
  c_timer2_request: cover property (@(posedge core_clk) disable iff (srst) $rose(requests.timer2));
  c_spi_clear: cover property (@(posedge core_clk) disable iff (srst) $fell(spi_done_flag));
  c_serial_request: cover property (@(posedge core_clk) disable iff (srst) $rose(requests.serial));
endmodule : interrupt_enable_logic

// ---- hdl/irq_enable_pkg.sv ----
// package for the interrupt enable logic: bit positions, reset values, carriers
// assumes one core clock and a synchronous reset shared with the core
package irq_enable_pkg;
  localparam int unsigned ENABLE_WIDTH = 8;
  localparam int unsigned SOURCE_COUNT = 6;
  // bit positions inside interrupt_enable
  localparam int unsigned BIT_EXT0 = 0;
  localparam int unsigned BIT_TIMER0 = 1;
  localparam int unsigned BIT_EXT1 = 2;
  localparam int unsigned BIT_TIMER1 = 3;
  localparam int unsigned BIT_SERIAL = 4;
  localparam int unsigned BIT_TIMER2 = 5;
  localparam int unsigned BIT_RESERVED = 6;
  localparam int unsigned BIT_GLOBAL = 7;
  // value after reset and mask of implemented bits
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] ENABLE_IMPL_MASK = 8'hBF;
  // machine cycle: 6 states of 2 phases = 12 core clocks
  localparam int unsigned CYCLE_TICKS = 12;
  localparam logic [3:0] TICK_S2P2 = 4'h3;
  localparam logic [3:0] TICK_S5P2 = 4'h9;
  localparam logic [3:0] TICK_LAST = 4'hB;
  localparam logic [3:0] TICK_RESET = 4'h0;

  // raw events from the peripherals
  typedef struct packed {
    logic timer0_overflow;
    logic timer1_overflow;
    logic timer2_overflow;
    logic timer2_external;
    logic spi_done;
    logic uart_flag;
  } event_type;

  // software actions on flags
  typedef struct packed {
    logic timer0_clear;
    logic timer1_clear;
    logic timer2_overflow_clear;
    logic timer2_external_clear;
    logic spi_status_read;
    logic spi_data_access;
  } flag_ctrl_type;

  // requests in vector order ext0, timer0, ext1, timer1, serial, timer2
  typedef struct packed {
    logic timer2;
    logic serial;
    logic timer1;
    logic ext1;
    logic timer0;
    logic ext0;
  } request_type;
endpackage : irq_enable_pkg

// ---- sim/interrupt_enable_logic_test.sv ----
// testbench for the interrupt enable logic, one task per scenario
// assumes inputs change at the falling edge of a 100 MHz core_clk
`timescale 1ns/1ps
module interrupt_enable_logic_test;
  import irq_enable_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic pin0_n = 1'b1;
  logic pin1_n = 1'b1;
  logic enable_write = 1'b0;
  logic [7:0] enable_wdata = 8'h00;
  logic spi_en = 1'b0;
  logic service_en = 1'b0;
  event_type events = '0;
  flag_ctrl_type tb_ctrl = '0;
  flag_ctrl_type flag_ctrl;
  logic vector_taken, ovf_clear, ext_clear, t2o, t2e, spi_flag, strobe;
  logic [7:0] ie;
  request_type requests;
  int fail_count = 0;
  int compares = 0;
  int eb [6] = '{0, 5, 0, 4, 0, 2};
  // software clears merged with the core model's clears
  assign flag_ctrl = tb_ctrl | {2'b00, ovf_clear, ext_clear, 2'b00};
  interrupt_enable_logic interrupt_enable_logic_i (.core_clk(core_clk), .srst(srst),
    .ext_irq_pin_zero_n(pin0_n), .ext_irq_pin_one_n(pin1_n), .enable_write(enable_write),
    .enable_wdata(enable_wdata), .spi_irq_enable(spi_en), .events(events), .flag_ctrl(flag_ctrl),
    .vector_taken(vector_taken), .interrupt_enable(ie), .requests(requests), .timer2_overflow_flag(t2o),
    .timer2_external_flag(t2e), .spi_done_flag(spi_flag), .sample_strobe(strobe));
  irq_core_model irq_core_model_i (.core_clk(core_clk), .srst(srst), .service_en(service_en),
    .timer2_request(requests.timer2), .timer2_overflow_flag(t2o), .timer2_external_flag(t2e),
    .vector_taken(vector_taken), .ovf_clear(ovf_clear), .ext_clear(ext_clear));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task report_and_stop;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task check(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  task wr(input logic [7:0] v);
    enable_wdata = v;
    enable_write = 1'b1;
    tick(1);
    enable_write = 1'b0;
    tick(1);
  endtask : wr
  task ev(input int b);
    events[b] = 1'b1;
    tick(1);
    events[b] = 1'b0;
  endtask : ev
  task ctl(input int b);
    tb_ctrl[b] = 1'b1;
    tick(1);
    tb_ctrl = '0;
    tick(1);
  endtask : ctl
  task wait_req(input int b, input logic lvl);
    int n;
    n = 0;
    while (requests[b] !== lvl && n < 40) begin
      tick(1);
      n++;
    end
    if (n == 40) begin
      check(8'h00, 8'h01, "request wait timed out");
      report_and_stop();
    end
  endtask : wait_req
  task test_register;
    check(ie, 8'h00, "reset enable");
    check({2'b00, requests}, 8'h00, "reset requests");
    wr(8'hBF);
    check(ie, 8'hBF, "implemented bits stored");
    wr(8'h40);
    check(ie, 8'h00, "bit6 only");
    $display("test_register done");
  endtask : test_register
  task test_sources;
    for (int i = 0; i < 6; i++) begin
      wr(8'h80 | (8'h3F & ~(8'h01 << i)));
      if (i == 0) pin0_n = 1'b0;
      else if (i == 2) pin1_n = 1'b0;
      else if (i == 4) events.uart_flag = 1'b1;
      else ev(eb[i]);
      tick(30);
      check({2'b00, requests}, 8'h00, "own enable clear");
      wr(8'h01 << i);
      tick(30);
      check({2'b00, requests}, 8'h00, "global clear");
      wr(8'h80 | (8'h01 << i));
      wait_req(i, 1'b1);
      check({2'b00, requests}, 8'h01 << i, "request position");
      tick(20);
      check({2'b00, requests}, 8'h01 << i, "request holds");
      pin0_n = 1'b1;
      pin1_n = 1'b1;
      events.uart_flag = 1'b0;
      if (i % 2) ctl(eb[i]);
      wait_req(i, 1'b0);
    end
    $display("test_sources done");
  endtask : test_sources
  task test_spi;
    wr(8'h90);
    ev(1);
    tick(20);
    check({spi_flag, requests.serial}, 2'b10, "spi enable off");
    spi_en = 1'b1;
    wait_req(4, 1'b1);
    ctl(0);
    tick(3);
    check(spi_flag, 1'b1, "data access alone");
    ctl(1);
    ctl(0);
    tick(3);
    check(spi_flag, 1'b0, "status then data");
    wait_req(4, 1'b0);
    spi_en = 1'b0;
    $display("test_spi done");
  endtask : test_spi
  task test_timer2;
    wr(8'hA0);
    service_en = 1'b1;
    events = 6'b001100;
    tick(1);
    events = '0;
    wait_req(5, 1'b1);
    tick(2);
    check({t2o, t2e}, 2'b11, "flags kept on vector");
    wait_req(5, 1'b0);
    check({t2o, t2e}, 2'b00, "handler cleared both");
    service_en = 1'b0;
    $display("test_timer2 done");
  endtask : test_timer2
  task test_timing;
    int n;
    wr(8'hA2);
    n = 0;
    while (strobe !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check(strobe, 1'b1, "sample strobe");
    events = 6'b101000;
    tick(1);
    events = '0;
    tick(8);
    check({2'b00, requests}, 8'h20, "timer2 first");
    wait_req(1, 1'b1);
    check({2'b00, requests}, 8'h22, "both pending");
    ctl(5);
    ctl(3);
    wait_req(5, 1'b0);
    $display("test_timing done");
  endtask : test_timing
  initial begin
    tick(4);
    srst = 1'b0;
    test_register();
    test_sources();
    test_spi();
    test_timer2();
    test_timing();
    report_and_stop();
  end
endmodule : interrupt_enable_logic_test

// ---- sim/irq_core_model.sv ----
// core model: vectors to the timer2 handler and clears the cause it finds
// assumes the block's outputs settle after the rising edge of core_clk
`timescale 1ns/1ps
module irq_core_model (
  // clock, reset and control
  input wire logic core_clk,
  input wire logic srst,
  input wire logic service_en,
  // view of the block
  input wire logic timer2_request,
  input wire logic timer2_overflow_flag,
  input wire logic timer2_external_flag,
  // core actions
  output logic vector_taken,
  output logic ovf_clear,
  output logic ext_clear
);
  logic [3:0] wait_count;
  initial begin
    vector_taken = 1'b0;
    ovf_clear = 1'b0;
    ext_clear = 1'b0;
    wait_count = 4'h0;
  end
  // vector on request, then the handler clears one flag in software
  always @(negedge core_clk) begin
    vector_taken <= 1'b0;
    ovf_clear <= 1'b0;
    ext_clear <= 1'b0;
    if (srst || !service_en) begin
      wait_count <= 4'h0;
    end else if (wait_count != 4'h0) begin
      wait_count <= wait_count - 4'h1;
    end else if (timer2_request) begin
      vector_taken <= 1'b1;
      wait_count <= 4'h6;
    end
    if (wait_count == 4'h5) begin
      ovf_clear <= timer2_overflow_flag;
      ext_clear <= !timer2_overflow_flag && timer2_external_flag;
    end
  end
endmodule : irq_core_model
